//--- hw/gpt_pkg.sv
// gpt_pkg: shared constants and types for the trigger polarity and maintenance terminal block
package gpt_pkg;
  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [7:0] POL_ADDR = 8'h0F;
  localparam logic [7:0] INS_ADDR = 8'h12;
  localparam logic [7:0] VER_ADDR = 8'h20;
  localparam logic [7:0] STAT_ADDR = 8'h21;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] INS_RESET = 8'h00;
  localparam int RX_POL_LSB = 0;
  localparam int TX_POL_LSB = 4;
  localparam int INS_EN_BIT = 7;
  localparam int NUM_LINES = 2;
  // ----------------------------------------
  // serial timing
  // ----------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int BAUD = 115200;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int DATA_BITS = 8;
  // ----------------------------------------
  // terminal command characters
  // ----------------------------------------
  localparam logic [7:0] CMD_WRITE = 8'h31;
  localparam logic [7:0] CMD_READ = 8'h32;
  localparam logic [7:0] CMD_CLEAR = 8'h33;
  localparam logic [7:0] CMD_HANDOVER = 8'h34;
  localparam logic [7:0] CMD_REBOOT = 8'h35;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_TERMINAL} gpt_mode_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } gpt_byte_t;
endpackage : gpt_pkg

//--- hw/gpt_top.sv
// gpt_top: trigger polarity registers, insertion gate and serial maintenance terminal
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module gpt_top #(
  parameter int BIT_CYCLES = gpt_pkg::BIT_CYC,
  parameter logic [7:0] VERSION = 8'h5A // arbitrary version value
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // boot straps
  input wire logic boot_option_jumper,
  input wire logic front_edge_usb_override_switch,
  input wire logic [1:0] sw_port_sel,
  // trigger lines (contacts pull to ground)
  input wire logic [gpt_pkg::NUM_LINES-1:0] trig_in,
  input wire logic [gpt_pkg::NUM_LINES-1:0] stream_rx_bits,
  // trigger results
  output logic [gpt_pkg::NUM_LINES-1:0] stream_tx_bits,
  output logic stream_tx_valid,
  output logic [gpt_pkg::NUM_LINES-1:0] trig_out,
  // remote control message port
  input wire logic remote_we,
  input wire logic [7:0] remote_addr,
  input wire logic [7:0] remote_wdata,
  output logic [7:0] remote_rdata,
  // serial ports: 0 rs232, 1 network virtual serial port, 2 usb
  input wire logic [2:0] ser_rxd,
  output logic [2:0] ser_txd,
  // status
  output logic terminal_mode,
  output logic reboot_req
);
  // ----------------------------------------
  // straps caught after reset release
  // ----------------------------------------
  logic strap_done_reg;
  logic [1:0] port_reg;
  gpt_pkg::gpt_mode_t mode_reg;
  logic term_cmd_handover;
  wire [1:0] port_next = front_edge_usb_override_switch ? 2'h2 : sw_port_sel;
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_done_reg <= 1'b0;
      port_reg <= 2'h0;
      mode_reg <= gpt_pkg::MODE_NORMAL;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      if (boot_option_jumper) begin
        mode_reg <= gpt_pkg::MODE_TERMINAL;
        port_reg <= port_next;
      end
    end else if (term_cmd_handover) begin
      mode_reg <= gpt_pkg::MODE_NORMAL;
    end
  end
  wire term_on = (mode_reg == gpt_pkg::MODE_TERMINAL);
  // ----------------------------------------
  // serial port and byte engine
  // ----------------------------------------
  gpt_pkg::gpt_byte_t rx_b;
  gpt_pkg::gpt_byte_t tx_b;
  logic tx_busy;
  logic txd_w;
  wire rxd_w = ser_rxd[port_reg];
  gpt_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .clk(clk),
    .srst(srst),
    .rxd(rxd_w),
    .txd(txd_w),
    .rx_byte(rx_b),
    .tx_byte(tx_b),
    .tx_busy(tx_busy)
  );
  // command parser: cmd byte, then address and data as needed
  logic [1:0] step_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_reg;
  wire rx_ok = rx_b.valid && term_on;
  wire at_cmd = rx_ok && (step_reg == 2'h0);
  wire term_cmd_clear = at_cmd && (rx_b.data == gpt_pkg::CMD_CLEAR);
  assign term_cmd_handover = at_cmd && (rx_b.data == gpt_pkg::CMD_HANDOVER);
  wire term_cmd_reboot = at_cmd && (rx_b.data == gpt_pkg::CMD_REBOOT);
  wire needs_addr = (rx_b.data == gpt_pkg::CMD_WRITE) || (rx_b.data == gpt_pkg::CMD_READ);
  wire term_read = rx_ok && (step_reg == 2'h1) && (cmd_reg == gpt_pkg::CMD_READ);
  wire term_we = rx_ok && (step_reg == 2'h2);
  always_ff @(posedge clk) begin
    if (srst) begin
      step_reg <= 2'h0;
      cmd_reg <= 8'h00;
      addr_reg <= 8'h00;
    end else if (rx_ok) begin
      unique case (step_reg)
        2'h0: begin
          cmd_reg <= rx_b.data;
          step_reg <= needs_addr ? 2'h1 : 2'h0;
        end
        2'h1: begin
          addr_reg <= rx_b.data;
          step_reg <= (cmd_reg == gpt_pkg::CMD_WRITE) ? 2'h2 : 2'h0;
        end
        default: step_reg <= 2'h0;
      endcase
    end
  end
  // ----------------------------------------
  // register bank
  // ----------------------------------------
  logic [7:0] pol_reg;
  logic [7:0] ins_reg;
  // remote writes are dropped while the terminal owns the bank
  wire rem_we = remote_we && !term_on;
  wire [7:0] wr_addr = term_on ? addr_reg : remote_addr;
  wire [7:0] wr_data = term_on ? rx_b.data : remote_wdata;
  wire wr_en = term_we || rem_we;
  always_ff @(posedge clk) begin
    if (srst || term_cmd_clear) begin
      pol_reg <= gpt_pkg::POL_RESET;
      ins_reg <= gpt_pkg::INS_RESET;
    end else if (wr_en) begin
      if (wr_addr == gpt_pkg::POL_ADDR) pol_reg <= wr_data;
      if (wr_addr == gpt_pkg::INS_ADDR) ins_reg <= wr_data;
    end
  end
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] p,
                                        input logic [7:0] i, input logic [7:0] st);
    unique case (a)
      gpt_pkg::POL_ADDR: rd_mux = p;
      gpt_pkg::INS_ADDR: rd_mux = i;
      gpt_pkg::VER_ADDR: rd_mux = VERSION; // read only, not cleared
      gpt_pkg::STAT_ADDR: rd_mux = st; // read only, live state
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux
  wire [7:0] stat_w = {4'h0, port_reg, boot_option_jumper, term_on};
  always_ff @(posedge clk) begin
    if (srst) begin
      remote_rdata <= 8'h00;
      tx_b <= '0;
    end else begin
      remote_rdata <= term_on ? 8'h00 : rd_mux(remote_addr, pol_reg, ins_reg, stat_w);
      tx_b.valid <= term_read && !tx_busy; // reply dropped if a byte is still going out
      tx_b.data <= rd_mux(rx_b.data, pol_reg, ins_reg, stat_w);
    end
  end
  // ----------------------------------------
  // trigger polarity and insertion
  // ----------------------------------------
  // inputs close to ground, so a low level asserts when the bit is 0
  wire [1:0] rx_pol = pol_reg[gpt_pkg::RX_POL_LSB +: gpt_pkg::NUM_LINES];
  wire [1:0] tx_pol = pol_reg[gpt_pkg::TX_POL_LSB +: gpt_pkg::NUM_LINES];
  wire [1:0] trig_act = trig_in ^ ~rx_pol;
  wire [1:0] out_lvl = stream_rx_bits ^ ~tx_pol;
  wire ins_en = ins_reg[gpt_pkg::INS_EN_BIT];
  always_ff @(posedge clk) begin
    if (srst) begin
      stream_tx_bits <= '0;
      stream_tx_valid <= 1'b0;
      trig_out <= '0;
      ser_txd <= 3'h7;
      terminal_mode <= 1'b0;
      reboot_req <= 1'b0;
    end else begin
      stream_tx_bits <= ins_en ? trig_act : '0;
      stream_tx_valid <= ins_en;
      trig_out <= out_lvl;
      ser_txd <= 3'h7;
      ser_txd[port_reg] <= term_on ? txd_w : 1'b1;
      terminal_mode <= term_on;
      reboot_req <= term_cmd_reboot;
    end
  end
endmodule : gpt_top

//--- hw/gpt_uart.sv
// gpt_uart: 8N1 serial receiver and transmitter without flow control
`timescale 1ns/1ps
module gpt_uart #(
  parameter int BIT_CYCLES = gpt_pkg::BIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic rxd,
  output logic txd,
  // byte side
  output gpt_pkg::gpt_byte_t rx_byte,
  input wire gpt_pkg::gpt_byte_t tx_byte,
  output logic tx_busy
);
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic [15:0] rcnt_reg;
  logic [3:0] rbit_reg;
  logic [8:0] rsh_reg;
  logic rbusy_reg;
  wire rtick = (rcnt_reg == 16'h0000);
  always_ff @(posedge clk) begin
    rx_byte.valid <= 1'b0;
    if (srst) begin
      rbusy_reg <= 1'b0;
      rcnt_reg <= 16'h0000;
      rbit_reg <= 4'h0;
      rsh_reg <= 9'h000;
      rx_byte.data <= 8'h00;
    end else if (!rbusy_reg) begin
      if (!rxd) begin // sample mid start bit
        rbusy_reg <= 1'b1;
        rcnt_reg <= 16'(BIT_CYCLES / 2);
        rbit_reg <= 4'h0;
      end
    end else if (rtick) begin
      rcnt_reg <= 16'(BIT_CYCLES - 1);
      rsh_reg <= {rxd, rsh_reg[8:1]};
      rbit_reg <= rbit_reg + 4'h1;
      if (rbit_reg == 4'(gpt_pkg::DATA_BITS + 1)) begin // one stop bit, no parity
        rbusy_reg <= 1'b0;
        rx_byte.valid <= rxd;
        rx_byte.data <= rsh_reg[8:1];
      end
    end else begin
      rcnt_reg <= rcnt_reg - 16'h0001;
    end
  end
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [15:0] tcnt_reg;
  logic [3:0] tbit_reg;
  logic [9:0] tsh_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      txd <= 1'b1;
      tx_busy <= 1'b0;
      tcnt_reg <= 16'h0000;
      tbit_reg <= 4'h0;
      tsh_reg <= 10'h3FF;
    end else if (!tx_busy) begin
      if (tx_byte.valid) begin
        tx_busy <= 1'b1;
        tsh_reg <= {1'b1, tx_byte.data, 1'b0}; // 8N1 frame
        tcnt_reg <= 16'h0000;
        tbit_reg <= 4'h0;
      end
    end else if (tcnt_reg == 16'h0000) begin
      txd <= tsh_reg[0];
      tsh_reg <= {1'b1, tsh_reg[9:1]};
      tcnt_reg <= 16'(BIT_CYCLES - 1);
      tbit_reg <= tbit_reg + 4'h1;
      if (tbit_reg == 4'(gpt_pkg::DATA_BITS + 2)) begin
        tx_busy <= 1'b0;
      end
    end else begin
      tcnt_reg <= tcnt_reg - 16'h0001;
    end
  end
endmodule : gpt_uart

//--- sim/gpi_polarity_terminal_regs_tb_top.sv
// gpi_polarity_terminal_regs_tb_top: self-checking bench for the trigger terminal block
`timescale 1ns/1ps
module gpi_polarity_terminal_regs_tb_top;
  localparam int BITC = 8;
  logic clk = 1'b0, srst = 1'b1, jmp = 1'b1, usb_sw = 1'b0, we = 1'b0;
  logic [1:0] port_sel = 2'h0, port_idx = 2'h0, trig_in = 2'h0, rx_bits = 2'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pol, exp_q[$];
  logic [1:0] tx_bits, trig_out;
  logic [2:0] ser_rxd, ser_txd;
  logic tx_valid, term, reboot, host_txd, host_rxd;
  gpt_pkg::gpt_byte_t host_byte;
  int errors = 0, checks = 0, reboots = 0;
  integer seed = 32'hD442EEE6;
  always #10 clk = ~clk;
  // unselected ports idle high
  assign ser_rxd = ~({2'h0, ~host_txd} << port_idx);
  assign host_rxd = ser_txd[port_idx];
  gpt_top #(.BIT_CYCLES(BITC)) u_dut (.clk(clk), .srst(srst), .boot_option_jumper(jmp),
    .front_edge_usb_override_switch(usb_sw), .sw_port_sel(port_sel), .trig_in(trig_in),
    .stream_rx_bits(rx_bits), .stream_tx_bits(tx_bits), .stream_tx_valid(tx_valid),
    .trig_out(trig_out), .remote_we(we), .remote_addr(addr), .remote_wdata(wdata),
    .remote_rdata(rdata), .ser_rxd(ser_rxd), .ser_txd(ser_txd), .terminal_mode(term),
    .reboot_req(reboot));
  gpt_host_model #(.BIT_CYCLES(BITC)) u_host (.clk(clk), .host_txd(host_txd),
    .host_rxd(host_rxd), .rx_byte(host_byte));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic cmd(input logic [7:0] b);
    u_host.send_byte(b, $unsigned($random(seed)) % 3);
  endtask : cmd
  task automatic term_wr(input logic [7:0] a, input logic [7:0] d);
    cmd(gpt_pkg::CMD_WRITE);
    cmd(a);
    cmd(d);
  endtask : term_wr
  task automatic term_rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    cmd(gpt_pkg::CMD_READ);
    cmd(a);
    for (int i = 0; i < 30 * BITC && exp_q.size() != 0; i++) @(posedge clk);
  endtask : term_rd
  task automatic rem_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 we = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 we = 1'b0;
  endtask : rem_wr
  task automatic rem_rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    repeat (2) @(posedge clk);
    #1 check("remote_rdata", exp, rdata);
  endtask : rem_rd
  task automatic do_reset(input logic j, input logic s, input logic [1:0] p);
    @(posedge clk);
    #1 srst = 1'b1;
    jmp = j;
    usb_sw = s;
    port_sel = p;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge clk);
    // leave the edge so later stimulus and samples stay off it
    #1;
  endtask : do_reset
  // closed contact reads low, so random levels cover both states
  task automatic pol_check(input logic [7:0] p, input logic ins);
    repeat (4) begin
      @(posedge clk);
      #1 trig_in = 2'($random(seed));
      rx_bits = 2'($random(seed));
      repeat (3) @(posedge clk);
      #1 check("stream_tx_bits", {6'h0, (trig_in ^ ~p[1:0]) & {2{ins}}}, {6'h0, tx_bits});
      check("trig_out", {6'h0, rx_bits ^ ~p[5:4]}, {6'h0, trig_out});
      check("stream_tx_valid", {7'h0, ins}, {7'h0, tx_valid});
    end
  endtask : pol_check
  // replies are compared oldest first against what the driver noted
  always @(posedge host_byte.valid) begin
    check("reply", (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX, host_byte.data);
  end
  always @(posedge clk) begin
    if (reboot === 1'b1) reboots++;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    do_reset(1'b1, 1'b0, 2'h0);
    check("terminal_mode", 8'h01, {7'h0, term});
    pol = 8'($random(seed));
    term_wr(gpt_pkg::POL_ADDR, pol);
    term_wr(gpt_pkg::INS_ADDR, 8'h80);
    term_rd(gpt_pkg::POL_ADDR, pol);
    pol_check(pol, 1'b1);
    rem_wr(gpt_pkg::POL_ADDR, ~pol);
    rem_rd(gpt_pkg::VER_ADDR, 8'h00);
    term_rd(gpt_pkg::POL_ADDR, pol);
    cmd(gpt_pkg::CMD_CLEAR);
    term_rd(gpt_pkg::POL_ADDR, 8'h00);
    term_rd(gpt_pkg::INS_ADDR, 8'h00);
    term_rd(gpt_pkg::VER_ADDR, 8'h5A);
    pol_check(8'h00, 1'b0);
    cmd(gpt_pkg::CMD_REBOOT);
    do_reset(1'b1, 1'b1, 2'h1);
    port_idx = 2'h2;
    check("reboots", 8'h01, 8'(reboots));
    term_rd(gpt_pkg::STAT_ADDR, 8'h0B);
    cmd(gpt_pkg::CMD_HANDOVER);
    for (int i = 0; i < 20 && term; i++) @(posedge clk) #1;
    check("terminal_mode", 8'h00, {7'h0, term});
    repeat (8) @(posedge clk);
    rem_wr(gpt_pkg::POL_ADDR, pol);
    rem_wr(gpt_pkg::INS_ADDR, 8'h80);
    rem_rd(gpt_pkg::POL_ADDR, pol);
    pol_check(pol, 1'b1);
    do_reset(1'b0, 1'b0, 2'h0);
    port_idx = 2'h0;
    check("terminal_mode", 8'h00, {7'h0, term});
    term_wr(gpt_pkg::POL_ADDR, 8'h11);
    rem_rd(gpt_pkg::POL_ADDR, 8'h00);
    rem_rd(gpt_pkg::VER_ADDR, 8'h5A);
    check("pending", 8'h00, 8'(exp_q.size()));
    stop_test();
  end
endmodule : gpi_polarity_terminal_regs_tb_top

//--- sim/gpt_host_model.sv
// gpt_host_model: host terminal emulator on the maintenance serial line
`timescale 1ns/1ps
module gpt_host_model #(
  parameter int BIT_CYCLES = 8
) (
  // clock
  input wire logic clk,
  // serial lines, idle high
  output logic host_txd,
  input wire logic host_rxd,
  // bytes heard from the device, valid one cycle
  output gpt_pkg::gpt_byte_t rx_byte
);
  logic [7:0] rx_sh;
  initial host_txd = 1'b1;
  initial rx_byte = '0;
  // 8 data bits lsb first, 1 stop, no parity; gap adds idle bits for a slow host
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10 + gap; i++) begin
      @(posedge clk);
      #1 host_txd = (i < 10) ? fr[i] : 1'b1;
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask : send_byte
  // no handshake lines: listens whenever the line falls
  always begin
    @(negedge host_rxd);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      rx_sh[i] = host_rxd;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    #1 rx_byte = {host_rxd, rx_sh};
    @(posedge clk);
    #1 rx_byte.valid = 1'b0;
  end
endmodule : gpt_host_model

//--- sim/gpt_top_props.sv
// gpt_top_props: port assertions for the trigger terminal block
`timescale 1ns/1ps
module gpt_top_props #(
  parameter logic [7:0] VERSION = 8'h5A // arbitrary version value
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // trigger path
  input wire logic [1:0] trig_in,
  input wire logic [1:0] stream_rx_bits,
  input wire logic [1:0] stream_tx_bits,
  input wire logic stream_tx_valid,
  input wire logic [1:0] trig_out,
  // remote port and status
  input wire logic remote_we,
  input wire logic [7:0] remote_addr,
  input wire logic [7:0] remote_wdata,
  input wire logic [7:0] remote_rdata,
  input wire logic terminal_mode,
  input wire logic reboot_req
);
  // settled-cycle counts; the mode output lags, so early edges are left alone
  logic [2:0] norm_reg;
  logic [2:0] quiet_reg;
  always_ff @(posedge clk) begin
    norm_reg <= (srst || terminal_mode) ? 3'h0 : norm_reg + {2'h0, norm_reg != 3'h7};
    quiet_reg <= (srst || terminal_mode || remote_we) ? 3'h0 :
                 quiet_reg + {2'h0, quiet_reg != 3'h7};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wr(a);
    remote_we && norm_reg == 3'h7 && remote_addr == a;
  endsequence
  chk_ins_gate: assert property (!stream_tx_valid |-> stream_tx_bits == 2'h0)
    else $error("stream bits while insertion off");
  chk_ins_copy: assert property (
    s_wr(8'h12) |=> ##1 stream_tx_valid == $past(remote_wdata[7], 2))
    else $error("insertion enable not applied");
  chk_pol_back: assert property (
    s_wr(8'h0F) ##1 remote_addr == 8'h0F |=> remote_rdata == $past(remote_wdata, 2))
    else $error("polarity write not read back");
  chk_ver_read: assert property (
    norm_reg == 3'h7 && $past(remote_addr) == 8'h20 |-> remote_rdata == VERSION)
    else $error("read-only value wrong");
  chk_rx_flip: assert property (quiet_reg == 3'h7 |->
    (trig_out ^ $past(trig_out)) == ($past(stream_rx_bits) ^ $past(stream_rx_bits, 2)))
    else $error("trigger output does not follow stream bits");
  chk_tx_flip: assert property (
    quiet_reg == 3'h7 && stream_tx_valid && $past(stream_tx_valid) |->
    (stream_tx_bits ^ $past(stream_tx_bits)) == ($past(trig_in) ^ $past(trig_in, 2)))
    else $error("stream bits do not follow trigger inputs");
  chk_reboot_pulse: assert property (reboot_req |-> terminal_mode ##1 !reboot_req)
    else $error("reboot pulse malformed");
  chk_term_quiet: assert property (
    terminal_mode && $past(terminal_mode) |-> remote_rdata == 8'h00)
    else $error("remote read answered in terminal mode");
endmodule : gpt_top_props
bind gpt_top gpt_top_props #(.VERSION(VERSION)) u_props (.clk, .srst, .trig_in,
  .stream_rx_bits, .stream_tx_bits, .stream_tx_valid, .trig_out, .remote_we, .remote_addr,
  .remote_wdata, .remote_rdata, .terminal_mode, .reboot_req);
